// *** stack_irq_if.sv ***
// Link between the program sequencer and the stack and interrupt unit
`timescale 1ns/1ps
interface stack_irq_if;
  import stack_irq_pkg::*;
  seq_op_e op; // Stack or enable order
  logic op_go; // Order strobe
  logic [12:0] cur_pc; // Return address of the current instruction
  logic [7:0] push_data; // Byte for a push
  logic boundary; // Next instruction about to start
  logic sleeping; // Core asleep
  logic io_we; // I/O write strobe
  logic io_re; // I/O read strobe
  logic [5:0] io_addr; // I/O offset
  logic [7:0] io_wdata; // I/O write byte
  logic busy; // Unit sequence running
  logic done; // Order finished
  logic [7:0] io_rdata; // I/O read byte
  logic [7:0] pop_data; // Popped byte
  logic [12:0] pc_pop; // Popped return address
  logic irq_take; // Interrupt accepted this cycle
  logic vec_valid; // Vector ready
  logic [12:0] vec_addr; // Vector address
  logic [12:0] reset_vec; // Reset vector address
  modport unit (input op, op_go, cur_pc, push_data, boundary, sleeping, io_we, io_re, io_addr,
    io_wdata, output busy, done, io_rdata, pop_data, pc_pop, irq_take, vec_valid, vec_addr,
    reset_vec);
  modport seq (output op, op_go, cur_pc, push_data, boundary, sleeping, io_we, io_re, io_addr,
    io_wdata, input busy, done, io_rdata, pop_data, pc_pop, irq_take, vec_valid, vec_addr,
    reset_vec);
endinterface

// *** stack_irq_pkg.sv ***
// Types shared by the stack and interrupt unit and its sequencer
package stack_irq_pkg;
  // Orders from the sequencer
  typedef enum logic [2:0] {OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_INTERRUPT_EXIT_INSTR, OP_CLI, OP_SEI}
    seq_op_e;
  // Unit sequence states
  typedef enum logic [3:0] {D_IDLE, D_POP_WAIT, D_POP_DATA, D_CALL_HI, D_RET_A, D_RET_HI,
    D_RET_LO, D_WAKE, D_ENT_LO, D_ENT_HI, D_ENT_WAIT} unit_state_e;
  // Whole state of the unit
  typedef struct packed {
    unit_state_e st;
    logic [10:0] sp;
    logic [7:0] status_flags_reg;
    logic [7:0] ien;
    logic [7:0] flag;
    logic [7:0] ctrl;
    logic hold_one;
    logic with_i;
    logic [2:0] cnt;
    logic [2:0] src;
    logic [12:0] pc_hold;
    logic [7:0] pop_hi;
    logic [10:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] pop_data;
    logic [12:0] pc_pop;
    logic done;
    logic vec_valid;
    logic [12:0] vec_addr;
    logic [7:0] io_rdata;
  } unit_s;
  // Whole state of the sequencer end
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    seq_op_e op;
    logic op_go;
    logic boundary;
    logic sleeping;
    logic [12:0] cur_pc;
    logic [7:0] push_data;
    logic io_we;
    logic io_re;
    logic io_wait;
    logic [5:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_cap;
    logic vec_seen;
    logic take_seen;
  } seq_s;
endpackage

// *** stack_irq_regs.svh ***
// Offsets, field positions, reset values and cycle counts of the stack and interrupt unit
`ifndef STACK_IRQ_REGS_SVH
`define STACK_IRQ_REGS_SVH
// Unit I/O register offsets
`define IO_SP_LOW 6'h3D
`define IO_SP_HIGH 6'h3E
`define IO_STATUS 6'h3F
`define IO_CPU_CTRL 6'h35
`define IO_IRQ_EN 6'h30
`define IO_IRQ_FLAG 6'h31
// Field positions and widths
`define GIE_BIT 7
`define RELOC_BIT 1
`define SP_HIGH_W 3
// Reset values
`define SP_RESET 11'h4FF
`define STATUS_RESET 8'h00
`define CTRL_RESET 8'h00
`define IEN_RESET 8'h00
// Source layout: low nibble latched flags, high nibble level requests
`define FLAG_TYPE_MASK 8'h0F
`define BOOT_START 13'h1C00
`define VEC_STRIDE 13'h0002
// Cycle counts
`define WAKE_CYCLES 3'h4
// Sequencer register byte offsets on AXI4-Lite
`define AX_CTRL 8'h00
`define AX_ARG 8'h04
`define AX_IO 8'h08
`define AX_STATUS 8'h0C
`define AX_VEC 8'h10
`define AX_POPPC 8'h14
`define AX_OKAY 2'h0
`define AX_SLVERR 2'h2
`endif

// *** stack_irq_seq.sv ***
// Sequencer end: takes orders over AXI4-Lite and drives the unit link
`timescale 1ns/1ps
`include "stack_irq_regs.svh"
module stack_irq_seq
  import stack_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  stack_irq_if.seq link,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  seq_s r; // Registered state
  seq_s n; // Next state

  // Bus handling and link drive
  always_comb begin
    n = r;
    n.op_go = 1'b0;
    n.boundary = 1'b0;
    n.io_we = 1'b0;
    n.io_re = 1'b0;
    // Capture unit I/O read byte one cycle after the strobe
    n.io_wait = r.io_re;
    if (r.io_wait) begin
      n.io_cap = link.io_rdata;
    end
    // Sticky link events, set beats clear
    n.vec_seen = r.vec_seen | link.vec_valid;
    n.take_seen = r.take_seen | link.irq_take;
    // Address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    // Write acts once both halves are held
    if (r.aw_got && r.w_got) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `AX_OKAY;
      unique case (r.aw_addr)
        `AX_CTRL: if (r.w_strb[0]) begin
          n.op = seq_op_e'(r.w_data[2:0]);
          n.op_go = r.w_data[3] && !link.busy; // Refused while busy
          n.boundary = r.w_data[4];
          n.sleeping = r.w_data[5];
        end
        `AX_ARG: begin
          if (r.w_strb[0]) n.cur_pc[7:0] = r.w_data[7:0];
          if (r.w_strb[1]) n.cur_pc[12:8] = r.w_data[12:8];
          if (r.w_strb[2]) n.push_data = r.w_data[23:16];
        end
        `AX_IO: if (r.w_strb[0]) begin
          n.io_addr = r.w_data[5:0];
          n.io_wdata = r.w_data[15:8];
          n.io_we = r.w_data[16];
          n.io_re = !r.w_data[16];
        end
        `AX_STATUS: if (r.w_strb[0]) begin
          n.vec_seen = (r.vec_seen & ~r.w_data[1]) | link.vec_valid;
          n.take_seen = (r.take_seen & ~r.w_data[2]) | link.irq_take;
        end
        `AX_VEC, `AX_POPPC: ;
        default: n.bresp = `AX_SLVERR;
      endcase
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Reads answer one cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = `AX_OKAY;
      n.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        `AX_CTRL: n.rdata = {26'h0, r.sleeping, 2'h0, r.op};
        `AX_ARG: n.rdata = {8'h00, r.push_data, 3'h0, r.cur_pc};
        `AX_IO: n.rdata = {16'h0000, r.io_wdata, 2'h0, r.io_addr};
        `AX_STATUS: n.rdata = {8'h00, link.pop_data, r.io_cap, 5'h00, r.take_seen,
          r.vec_seen, link.busy};
        `AX_VEC: n.rdata = {3'h0, link.reset_vec, 3'h0, link.vec_addr};
        `AX_POPPC: n.rdata = {19'h00000, link.pc_pop};
        default: n.rresp = `AX_SLVERR;
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.op <= OP_NONE;
    end else begin
      r <= n;
    end
  end

  // Handshake and link outputs
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign link.op = r.op;
  assign link.op_go = r.op_go;
  assign link.cur_pc = r.cur_pc;
  assign link.push_data = r.push_data;
  assign link.boundary = r.boundary;
  assign link.sleeping = r.sleeping;
  assign link.io_we = r.io_we;
  assign link.io_re = r.io_re;
  assign link.io_addr = r.io_addr;
  assign link.io_wdata = r.io_wdata;
endmodule

// *** stack_irq_sva.sv ***
// Timing checks on the link between the sequencer end and the unit
`timescale 1ns/1ps
module stack_irq_sva
  import stack_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire seq_op_e op,
  input wire logic op_go,
  input wire logic boundary,
  input wire logic sleeping,
  input wire logic busy,
  input wire logic done,
  input wire logic [12:0] pc_pop,
  input wire logic irq_take,
  input wire logic vec_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Order accepted by an idle unit with no competing take
  sequence s_go(seq_op_e o);
    op_go && op == o && !busy && !irq_take;
  endsequence
  property p_push; s_go(OP_PUSH) |=> done; endproperty
  a_push: assert property (p_push)
    else $error("push finish late");
  property p_call; s_go(OP_CALL) |-> ##2 done; endproperty
  a_call: assert property (p_call)
    else $error("call finish late");
  property p_pop; s_go(OP_POP) |-> ##3 done; endproperty
  a_pop: assert property (p_pop)
    else $error("pop finish late");
  property p_interrupt_exit_instr; s_go(OP_INTERRUPT_EXIT_INSTR) |-> ##4 done; endproperty
  a_interrupt_exit_instr: assert property (p_interrupt_exit_instr)
    else $error("return finish late");
  // Popped address moves only with a finish pulse
  property p_pc_hold; $changed(pc_pop) |-> done; endproperty
  a_pc_hold: assert property (p_pc_hold)
    else $error("popped address moved alone");
  property p_awake; irq_take && !sleeping |-> ##4 vec_valid; endproperty
  a_awake: assert property (p_awake)
    else $error("vector not after four cycles");
  property p_wake; irq_take && sleeping |-> ##8 vec_valid; endproperty
  a_wake: assert property (p_wake)
    else $error("wake vector not after eight cycles");
  property p_cli; op_go && op == OP_CLI && !busy |-> !irq_take; endproperty
  a_cli: assert property (p_cli)
    else $error("take beside disable order");
  // Take only at an instruction edge or in sleep of an idle unit, then no second take for four cycles
  property p_point; irq_take |-> (boundary || sleeping) && !busy; endproperty
  a_point: assert property (p_point)
    else $error("take inside a sequence");
  property p_once; irq_take |=> !irq_take [*4]; endproperty
  a_once: assert property (p_once)
    else $error("second take while disabled");
endmodule

// *** stack_irq_unit.sv ***
// Stack pointer and interrupt entry and return unit
// Behaviour
// - Push stores at top, pointer minus one
// - Calls and entry push address, minus two
// - Pop reads top, pointer plus one
// - Returns pop address, pointer plus two
// - Pointer in low and high byte registers
// - Pointer resets to last SRAM address
// - Runs on undivided core clock
// - Take needs source and global enable
// - Boot lock bits block by PC
// - Lower vector wins, reset highest
// - Relocate bit and fuse move vectors
// - Entry clears global enable bit
// - Vectoring or write-one clears flag
// - Disabled flag events stay latched
// - Level sources request only while present
// - One instruction after return first
// - Status flags never saved by hardware
// - Disable acts in same cycle
// - Instruction after enable runs first
// - Entry four cycles, pushes PC
// - Wake from sleep adds four cycles
// - Return four cycles, sets enable
// - Global enable is status bit seven
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "stack_irq_regs.svh"
module stack_irq_unit
  import stack_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  stack_irq_if.unit link,
  output logic [10:0] sram_addr,
  output logic sram_we,
  output logic [7:0] sram_wdata,
  input wire logic [7:0] sram_rdata,
  input wire logic [7:0] irq_event,
  input wire logic [7:0] irq_level,
  input wire logic boot_reset_vector_fuse,
  input wire logic [1:0] boot_lock_app_bits,
  input wire logic [1:0] boot_lock_boot_bits
);
  unit_s r; // Registered state
  unit_s n; // Next state
  logic [7:0] req; // Enabled requests
  logic gie_eff; // Global enable seen by this cycle
  logic lock_block; // Lock bits forbid taking
  logic take; // Accept an interrupt now
  logic [2:0] win; // Winning source
  logic in_boot; // Current PC in boot section
  logic [12:0] vbase; // Vector table base

  // Lowest index is the lowest vector, so it wins
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Request, gating and vector decisions
  always_comb begin
    // Flags latch, level sources are live
    req = ((r.flag & `FLAG_TYPE_MASK) | (irq_level & ~`FLAG_TYPE_MASK)) & r.ien;
    // Disable order and I/O clear act at once
    gie_eff = r.status_flags_reg[`GIE_BIT] & ~(link.op_go && link.op == OP_CLI)
      & ~(link.io_we && link.io_addr == `IO_STATUS && !link.io_wdata[`GIE_BIT]);
    in_boot = link.cur_pc >= `BOOT_START;
    // Programmed lock pair reads as other than all ones
    lock_block = ((boot_lock_app_bits != 2'h3) && !in_boot && r.ctrl[`RELOC_BIT])
      || ((boot_lock_boot_bits != 2'h3) && in_boot && !r.ctrl[`RELOC_BIT]);
    // Hold keeps one instruction before service
    take = (r.st == D_IDLE) && (link.boundary || link.sleeping) && gie_eff
      && !r.hold_one && !lock_block && (req != 8'h00);
    win = first_set(req);
    vbase = r.ctrl[`RELOC_BIT] ? `BOOT_START : 13'h0000;
  end

  // Next-state logic
  always_comb begin
    n = r;
    n.mem_we = 1'b0;
    n.done = 1'b0;
    n.vec_valid = 1'b0;
    n.io_rdata = r.io_rdata;
    // Boundary after a return or enable consumes the hold
    if (link.boundary && r.hold_one) begin
      n.hold_one = 1'b0;
    end
    unique case (r.st)
      D_IDLE: begin
        if (take) begin
          n.status_flags_reg[`GIE_BIT] = 1'b0;
          n.src = win;
          n.pc_hold = link.cur_pc;
          n.cnt = `WAKE_CYCLES - 3'h1;
          n.st = link.sleeping ? D_WAKE : D_ENT_LO;
        end else if (link.op_go) begin
          unique case (link.op)
            OP_PUSH: begin
              n.mem_we = 1'b1;
              n.mem_addr = r.sp;
              n.mem_wdata = link.push_data;
              n.sp = r.sp - 11'h001;
              n.done = 1'b1;
            end
            OP_POP: begin
              n.sp = r.sp + 11'h001;
              n.mem_addr = r.sp + 11'h001;
              n.st = D_POP_WAIT;
            end
            OP_CALL: begin
              n.pc_hold = link.cur_pc;
              n.mem_we = 1'b1;
              n.mem_addr = r.sp;
              n.mem_wdata = link.cur_pc[7:0];
              n.sp = r.sp - 11'h001;
              n.st = D_CALL_HI;
            end
            OP_RET, OP_INTERRUPT_EXIT_INSTR: begin
              n.with_i = link.op == OP_INTERRUPT_EXIT_INSTR;
              n.sp = r.sp + 11'h001;
              n.mem_addr = r.sp + 11'h001;
              n.st = D_RET_A;
            end
            OP_CLI: begin
              n.status_flags_reg[`GIE_BIT] = 1'b0;
              n.done = 1'b1;
            end
            OP_SEI: begin
              n.status_flags_reg[`GIE_BIT] = 1'b1;
              n.hold_one = 1'b1;
              n.done = 1'b1;
            end
            OP_NONE: begin
              n.done = 1'b1;
            end
          endcase
        end
      end
      // Synchronous SRAM gives data one cycle after the address
      D_POP_WAIT: begin
        n.st = D_POP_DATA;
      end
      D_POP_DATA: begin
        n.pop_data = sram_rdata;
        n.done = 1'b1;
        n.st = D_IDLE;
      end
      D_CALL_HI: begin
        n.mem_we = 1'b1;
        n.mem_addr = r.sp;
        n.mem_wdata = {3'h0, r.pc_hold[12:8]};
        n.sp = r.sp - 11'h001;
        n.done = 1'b1;
        n.st = D_IDLE;
      end
      D_RET_A: begin
        n.sp = r.sp + 11'h001;
        n.mem_addr = r.sp + 11'h001;
        n.st = D_RET_HI;
      end
      D_RET_HI: begin
        n.pop_hi = sram_rdata;
        n.st = D_RET_LO;
      end
      D_RET_LO: begin
        n.pc_pop = {r.pop_hi[4:0], sram_rdata};
        n.done = 1'b1;
        // Only the enable bit changes; other status bits stay as left
        if (r.with_i) begin
          n.status_flags_reg[`GIE_BIT] = 1'b1;
          n.hold_one = 1'b1;
        end
        n.st = D_IDLE;
      end
      // Extra wake-up cycles ahead of the entry sequence
      D_WAKE: begin
        n.cnt = r.cnt - 3'h1;
        if (r.cnt == 3'h0) begin
          n.st = D_ENT_LO;
        end
      end
      D_ENT_LO: begin
        n.mem_we = 1'b1;
        n.mem_addr = r.sp;
        n.mem_wdata = r.pc_hold[7:0];
        n.sp = r.sp - 11'h001;
        n.st = D_ENT_HI;
      end
      D_ENT_HI: begin
        n.mem_we = 1'b1;
        n.mem_addr = r.sp;
        n.mem_wdata = {3'h0, r.pc_hold[12:8]};
        n.sp = r.sp - 11'h001;
        n.st = D_ENT_WAIT;
      end
      D_ENT_WAIT: begin
        n.vec_valid = 1'b1;
        n.vec_addr = vbase + (13'({10'h000, r.src} + 13'h0001) * `VEC_STRIDE);
        n.st = D_IDLE;
      end
      default: begin
        n.st = D_IDLE;
      end
    endcase
    // Flag sources: set beats clear, vectoring and write-one clear
    begin
      logic [7:0] clr;
      clr = 8'h00;
      if (take) begin
        clr[win] = 1'b1;
      end
      if (link.io_we && link.io_addr == `IO_IRQ_FLAG) begin
        clr = clr | link.io_wdata;
      end
      n.flag = ((r.flag & ~clr) | irq_event) & `FLAG_TYPE_MASK;
    end
    // I/O register writes
    if (link.io_we) begin
      unique case (link.io_addr)
        `IO_SP_LOW: n.sp[7:0] = link.io_wdata;
        `IO_SP_HIGH: n.sp[10:8] = link.io_wdata[`SP_HIGH_W-1:0];
        `IO_STATUS: n.status_flags_reg = link.io_wdata;
        `IO_CPU_CTRL: n.ctrl = link.io_wdata & 8'h02;
        `IO_IRQ_EN: n.ien = link.io_wdata;
        default: ;
      endcase
    end
    // I/O register reads
    if (link.io_re) begin
      unique case (link.io_addr)
        `IO_SP_LOW: n.io_rdata = r.sp[7:0];
        `IO_SP_HIGH: n.io_rdata = {5'h00, r.sp[10:8]};
        `IO_STATUS: n.io_rdata = r.status_flags_reg;
        `IO_CPU_CTRL: n.io_rdata = r.ctrl;
        `IO_IRQ_EN: n.io_rdata = r.ien;
        `IO_IRQ_FLAG: n.io_rdata = r.flag | (irq_level & ~`FLAG_TYPE_MASK);
        default: n.io_rdata = 8'h00;
      endcase
    end
  end

  // Single state register on the undivided core clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= D_IDLE;
      r.sp <= `SP_RESET;
      r.status_flags_reg <= `STATUS_RESET;
      r.ctrl <= `CTRL_RESET;
      r.ien <= `IEN_RESET;
    end else begin
      r <= n;
    end
  end

  // Outputs
  assign link.busy = r.st != D_IDLE;
  assign link.done = r.done;
  assign link.io_rdata = r.io_rdata;
  assign link.pop_data = r.pop_data;
  assign link.pc_pop = r.pc_pop;
  assign link.irq_take = take;
  assign link.vec_valid = r.vec_valid;
  assign link.vec_addr = r.vec_addr;
  assign link.reset_vec = boot_reset_vector_fuse ? `BOOT_START : 13'h0000;
  assign sram_addr = r.mem_addr;
  assign sram_we = r.mem_we;
  assign sram_wdata = r.mem_wdata;
endmodule

// *** testbench.sv ***
// Bench joining sequencer and unit, driven over AXI4-Lite
`timescale 1ns/1ps
`include "stack_irq_regs.svh"
module testbench
  import stack_irq_pkg::*;
;
  typedef struct {seq_op_e op; logic [12:0] pc; logic [7:0] pd; logic [10:0] sp;
    logic [12:0] val;} row_s;
  logic clk = 1'b0, nrst = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, r;
  logic [1:0] rs;
  logic [10:0] sram_addr;
  logic sram_we;
  logic [7:0] sram_wdata, b, lo;
  logic [7:0] sram_rdata = 8'h00, irq_event = 8'h00, irq_level = 8'h00;
  logic fuse = 1'b0;
  logic [1:0] lock_app = 2'h3, lock_boot = 2'h3;
  logic [7:0] mem [0:2047]; // Stack SRAM
  logic [12:0] got;
  int err_count = 0, check_count = 0;
  // Ordinary orders and the state each should leave
  row_s rows [6] = '{'{OP_SEI, 13'h0, 8'h00, 11'h4FF, 13'h0080},
    '{OP_CLI, 13'h0, 8'h00, 11'h4FF, 13'h0000}, '{OP_PUSH, 13'h0, 8'hA5, 11'h4FE, 13'h00A5},
    '{OP_CALL, 13'h1234, 8'h00, 11'h4FC, 13'h1234}, '{OP_RET, 13'h0, 8'h00, 11'h4FE, 13'h1234},
    '{OP_POP, 13'h0, 8'h00, 11'h4FF, 13'h00A5}};
  stack_irq_if link();
  stack_irq_unit u_stack_irq_unit(.clk(clk), .nrst(nrst), .link(link), .sram_addr(sram_addr),
    .sram_we(sram_we), .sram_wdata(sram_wdata), .sram_rdata(sram_rdata), .irq_event(irq_event),
    .irq_level(irq_level), .boot_reset_vector_fuse(fuse), .boot_lock_app_bits(lock_app),
    .boot_lock_boot_bits(lock_boot));
  stack_irq_seq u_stack_irq_seq(.clk(clk), .nrst(nrst), .link(link), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  stack_irq_sva u_stack_irq_sva(.clk(clk), .nrst(nrst), .op(link.op), .op_go(link.op_go),
    .boundary(link.boundary), .sleeping(link.sleeping), .busy(link.busy), .done(link.done),
    .pc_pop(link.pc_pop), .irq_take(link.irq_take), .vec_valid(link.vec_valid));
  // Clock and synchronous SRAM
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (sram_we) mem[sram_addr] <= sram_wdata;
    sram_rdata <= mem[sram_addr];
  end
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_fail;
    err_count++;
    $display("FAIL t=%0t handshake never came", $time);
    report_and_stop();
  endtask
  // Write: address and data offered together, held until each is taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 40) wait_fail();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rdata;
        rs = rresp;
        break;
      end
    end
    rready <= 1'b0;
    if (n == 40) wait_fail();
  endtask
  // Unit I/O byte access through the sequencer
  task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
    axi_wr(8'h08, {15'h0, 1'b1, d, 2'h0, a});
    repeat (2) @(posedge clk);
  endtask
  task automatic io_rd(input logic [5:0] a);
    axi_wr(8'h08, {24'h0, 2'h0, a});
    repeat (3) @(posedge clk);
    axi_rd(8'h0C);
    b = r[15:8];
  endtask
  task automatic sp_chk(input logic [10:0] e);
    io_rd(6'h3D);
    lo = b;
    io_rd(6'h3E);
    check({b, lo}, {21'h0, e});
  endtask
  task automatic order(input seq_op_e o, input logic [12:0] pc, input logic [7:0] pd);
    axi_wr(8'h04, {8'h0, pd, 3'h0, pc});
    axi_wr(8'h00, {28'h0, 1'b1, o});
    repeat (8) @(posedge clk);
  endtask
  task automatic bnd;
    axi_wr(8'h0C, 32'h4);
    axi_wr(8'h00, 32'h10);
    repeat (12) @(posedge clk);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // Reset state, unused pointer bits, unmapped register
    sp_chk(11'h4FF);
    io_wr(6'h3E, 8'hFF);
    io_rd(6'h3E);
    check(b, 8'h07);
    io_wr(6'h3E, 8'h04);
    axi_rd(8'h40);
    check(rs, `AX_SLVERR);
    // Table of stack and enable orders
    for (int i = 0; i < 6; i++) begin
      order(rows[i].op, rows[i].pc, rows[i].pd);
      sp_chk(rows[i].sp);
      case (rows[i].op)
        OP_POP: begin axi_rd(8'h0C); got = {5'h0, r[23:16]}; end
        OP_RET: begin axi_rd(8'h14); got = r[12:0]; end
        OP_PUSH: got = {5'h0, mem[11'h4FF]};
        OP_CALL: got = {mem[11'h4FD][4:0], mem[11'h4FE]};
        default: begin io_rd(6'h3F); got = {5'h0, b}; end
      endcase
      check(got, rows[i].val);
    end
    // Reset vector follows the fuse
    axi_rd(8'h10);
    check(r[28:16], 13'h0000);
    fuse <= 1'b1;
    axi_rd(8'h10);
    check(r[28:16], 13'h1C00);
    // Two events latched while disabled, lower index served first
    @(posedge clk) irq_event <= 8'h06;
    @(posedge clk) irq_event <= 8'h00;
    io_rd(6'h31);
    check(b, 8'h06);
    io_wr(6'h30, 8'h06);
    order(OP_SEI, 13'h0ABC, 8'h00);
    bnd();
    axi_rd(8'h0C);
    check(r[2], 1'b0);
    bnd();
    axi_rd(8'h0C);
    check(r[2:1], 2'h3);
    axi_rd(8'h10);
    check(r[12:0], 13'h0004);
    io_rd(6'h31);
    check(b, 8'h04);
    io_rd(6'h3F);
    check(b, 8'h00);
    sp_chk(11'h4FD);
    check({mem[11'h4FE][4:0], mem[11'h4FF]}, 13'h0ABC);
    order(OP_INTERRUPT_EXIT_INSTR, 13'h0ABC, 8'h00);
    axi_rd(8'h14);
    check(r[12:0], 13'h0ABC);
    io_rd(6'h3F);
    check(b, 8'h80);
    bnd();
    axi_rd(8'h0C);
    check(r[2], 1'b0);
    bnd();
    axi_rd(8'h10);
    check(r[12:0], 13'h0006);
    // Level request that vanishes before enabling is never taken
    @(posedge clk) irq_level <= 8'h10;
    repeat (2) @(posedge clk);
    irq_level <= 8'h00;
    io_wr(6'h30, 8'h10);
    io_wr(6'h3F, 8'h8F);
    bnd();
    axi_rd(8'h0C);
    check(r[2], 1'b0);
    // Relocated vectors, lock block, then a take from sleep
    io_wr(6'h35, 8'h02);
    lock_app <= 2'h0;
    irq_level <= 8'h10;
    bnd();
    axi_rd(8'h0C);
    check(r[2], 1'b0);
    lock_app <= 2'h3;
    // Disable order on a boundary with a request pending
    axi_wr(8'h00, 32'h1E);
    repeat (4) @(posedge clk);
    axi_rd(8'h0C);
    check(r[2], 1'b0);
    io_wr(6'h3F, 8'h8F);
    axi_wr(8'h00, 32'h20);
    repeat (16) @(posedge clk);
    axi_wr(8'h00, 32'h0);
    irq_level <= 8'h00;
    axi_rd(8'h10);
    check(r[12:0], 13'h1C0A);
    io_rd(6'h3F);
    check(b, 8'h0F);
    // Boot-side lock pair blocks while vectors stay in place
    io_wr(6'h35, 8'h00);
    axi_wr(8'h04, 32'h0000_1C00);
    lock_boot <= 2'h0;
    irq_level <= 8'h10;
    io_wr(6'h3F, 8'h80);
    bnd();
    axi_rd(8'h0C);
    check(r[2], 1'b0);
    report_and_stop();
  end
endmodule
